/* hw/pll_cfg_pkg.sv */
// Purpose: Shared constants for the clock generator configuration decoder
// Assumes: One 128-bit image, AXI4-Lite register access, 32-bit data
// Notes: Field positions are bit indices into the configuration image
package pll_cfg_pkg;
    // Widths
    localparam int IMG_W = 128;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int BYTE_W = 8;
    localparam int REF_W = 8;
    localparam int FB_W = 11;
    localparam int ACNT_W = 3;
    localparam int MCNT_W = 8;
    localparam int CODE_W = 4;
    localparam int RATIO_W = 6;
    localparam int NUM_OUT = 4;
    localparam int NUM_PLL = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_IMG0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IMG1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IMG2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IMG3 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PLLC = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RATIO = 8'h14;
    localparam logic [1:0] WORD_LSB_ZERO = 2'h0;

    // Power-down enable positions
    localparam int OFF_PLL_A = 21;
    localparam int OFF_PLL_B = 45;
    localparam int OFF_PLL_C = 69;
    localparam int OFF_OUT_A = 120;
    localparam int OFF_OUT_B = 121;
    localparam int OFF_OUT_C = 122;
    localparam int OFF_OUT_D = 123;

    // Reference divider field bases
    localparam int REF_A_LO = 0;
    localparam int REF_B_LO = 24;
    localparam int REF_C1_LO = 48;
    localparam int REF_C2_LO = 72;

    // Feedback divider field bases; low part is the A-counter
    localparam int FB_A_LO = 8;
    localparam int FB_B_LO = 32;
    localparam int FB_C1_LO = 56;
    localparam int FB_C2_LO = 80;

    // Post divider modulus code bases
    localparam int CODE_A_LO = 96;
    localparam int CODE_B_LO = 100;
    localparam int CODE_C1_LO = 104;
    localparam int CODE_D1_LO = 108;
    localparam int CODE_C2_LO = 112;
    localparam int CODE_D2_LO = 116;

    // Loop filter and charge pump tuning positions
    localparam int LF_A = 20;
    localparam int LF_B = 44;
    localparam int LF_C1 = 68;
    localparam int LF_C2 = 92;
    localparam int PUMP_A = 19;
    localparam int PUMP_B = 43;
    localparam int PUMP_C1 = 67;
    localparam int PUMP_C2 = 91;

    // Reset value and bus answers
    localparam logic [IMG_W-1:0] IMG_RESET = '0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/ratio_link_if.sv */
// Purpose: Carries one modulus code to a decoder and its ratio back
// Assumes: Purely combinational path
// Notes: One instance per output post divider
`timescale 1ns/1ps
interface ratio_link_if;
    import pll_cfg_pkg::*;
    logic [CODE_W-1:0] code;
    logic [RATIO_W-1:0] ratio;
    modport lut (input code, output ratio);
    modport user (output code, input ratio);
endinterface

/* hw/outdiv_ratio_lut.sv */
// Purpose: Turns a 4-bit post divider code into its divide ratio
// Assumes: Code is stable while the ratio is sampled
// Notes: Combinational; the caller registers the result
`timescale 1ns/1ps
module outdiv_ratio_lut
    import pll_cfg_pkg::*;
(
    // Code in, ratio out
    ratio_link_if.lut lnk
);
    // Modulus table
    always_comb begin
        case (lnk.code)
            4'h0: lnk.ratio = 6'h01; // R10
            4'h1: lnk.ratio = 6'h02;
            4'h2: lnk.ratio = 6'h03;
            4'h3: lnk.ratio = 6'h04;
            4'h4: lnk.ratio = 6'h05;
            4'h5: lnk.ratio = 6'h06;
            4'h6: lnk.ratio = 6'h08; // R10
            4'h7: lnk.ratio = 6'h09;
            4'h8: lnk.ratio = 6'h0A;
            4'h9: lnk.ratio = 6'h0C;
            4'hA: lnk.ratio = 6'h0F;
            4'hB: lnk.ratio = 6'h10;
            4'hC: lnk.ratio = 6'h12;
            4'hD: lnk.ratio = 6'h14;
            4'hE: lnk.ratio = 6'h19; // R10
            4'hF: lnk.ratio = 6'h32; // R10
            default: lnk.ratio = 6'h01;
        endcase
    end
endmodule

/* hw/pll_clock_config_decode.sv */
// Purpose: Holds the 128-bit clock generator image and decodes its fields
// Assumes: All inputs synchronous to mclk; AXI4-Lite slave, one word each
// Notes: Decoded outputs follow the image and pins by one clock
// Operation
// R1 - Output divider power-down bits 120 to 123
// R2 - PLL power-down bits 21, 45, 69
// R3 - Eight-bit reference dividers from fixed fields
// R4 - Feedback split: low three A, high eight M
// R5 - PLL C feedback from set 1 or 2
// R6 - Select pin picks PLL C set
// R7 - Divider A and B codes fixed fields
// R8 - Divider C code chosen by select pin
// R9 - Divider D code chosen by select pin
// R10 - Modulus code to divide ratio table
// R11 - Filter bit: 0 short, 1 long
// R12 - Pump bit: 0 low, 1 high current
// R13 - Shutdown only while power-down input high
// R14 - Image cleared to zero at reset
`timescale 1ns/1ps
module pll_clock_config_decode
    import pll_cfg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Device pins
    input wire logic alt_set_select_pin,
    input wire logic powerdown_input,
    // Shutdown controls
    output logic pll_a_shutdown_en,
    output logic pll_b_shutdown_en,
    output logic pll_c_shutdown_en,
    output logic outdiv_a_shutdown_en,
    output logic outdiv_b_shutdown_en,
    output logic outdiv_c_shutdown_en,
    output logic outdiv_d_shutdown_en,
    // Reference dividers
    output logic [REF_W-1:0] ref_divisor_a,
    output logic [REF_W-1:0] ref_divisor_b,
    output logic [REF_W-1:0] ref_divisor_c,
    // Feedback counters
    output logic [ACNT_W-1:0] loop_acount_a,
    output logic [MCNT_W-1:0] loop_mcount_a,
    output logic [ACNT_W-1:0] loop_acount_b,
    output logic [MCNT_W-1:0] loop_mcount_b,
    output logic [ACNT_W-1:0] loop_acount_c,
    output logic [MCNT_W-1:0] loop_mcount_c,
    // Loop tuning
    output logic filter_long_a,
    output logic filter_long_b,
    output logic filter_long_c,
    output logic pump_high_a,
    output logic pump_high_b,
    output logic pump_high_c,
    // Post divider ratios
    output logic [RATIO_W-1:0] outdiv_ratio_a,
    output logic [RATIO_W-1:0] outdiv_ratio_b,
    output logic [RATIO_W-1:0] outdiv_ratio_c,
    output logic [RATIO_W-1:0] outdiv_ratio_d
);
    typedef struct packed {
        logic [IMG_W-1:0] img;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [DATA_W-1:0] w_data;
        logic [STRB_W-1:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
        logic sel;
        logic [NUM_PLL-1:0] off_pll;
        logic [NUM_OUT-1:0] off_out;
        logic [REF_W-1:0] ref_a;
        logic [REF_W-1:0] ref_b;
        logic [REF_W-1:0] ref_c;
        logic [FB_W-1:0] fb_a;
        logic [FB_W-1:0] fb_b;
        logic [FB_W-1:0] fb_c;
        logic [NUM_PLL-1:0] lf;
        logic [NUM_PLL-1:0] cp;
        logic [NUM_OUT-1:0][RATIO_W-1:0] ratio;
    } state_type;

    state_type q_reg;
    state_type q_next;
    logic [CODE_W-1:0] code_sel [NUM_OUT];
    logic [RATIO_W-1:0] ratio_w [NUM_OUT];
    ratio_link_if lnk [NUM_OUT] ();

    // Modulus codes; C and D follow the select pin
    assign code_sel[0] = q_reg.img[CODE_A_LO +: CODE_W]; // R7
    assign code_sel[1] = q_reg.img[CODE_B_LO +: CODE_W]; // R7
    assign code_sel[2] = alt_set_select_pin ?
        q_reg.img[CODE_C2_LO +: CODE_W] :
        q_reg.img[CODE_C1_LO +: CODE_W]; // R8
    assign code_sel[3] = alt_set_select_pin ?
        q_reg.img[CODE_D2_LO +: CODE_W] :
        q_reg.img[CODE_D1_LO +: CODE_W]; // R9

    // One ratio decoder per post divider
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_div
            assign lnk[g].code = code_sel[g];
            assign ratio_w[g] = lnk[g].ratio;
            outdiv_ratio_lut u_lut (
                .lnk(lnk[g])
            );
        end
    endgenerate

    // Bus handling, image update and field decode
    always_comb begin
        int base;
        base = 0;
        q_next = q_reg;
        // Response handshakes free the channels
        if (q_reg.bvalid && bready) begin
            q_next.bvalid = 1'b0;
        end
        if (q_reg.rvalid && rready) begin
            q_next.rvalid = 1'b0;
        end
        // Address and data may arrive in either order
        if (awvalid && q_reg.awready) begin
            q_next.aw_got = 1'b1;
            q_next.aw_addr = awaddr;
        end
        if (wvalid && q_reg.wready) begin
            q_next.w_got = 1'b1;
            q_next.w_data = wdata;
            q_next.w_strb = wstrb;
        end
        // Commit once both halves are held
        if (q_next.aw_got && q_next.w_got && !q_next.bvalid) begin
            q_next.aw_got = 1'b0;
            q_next.w_got = 1'b0;
            q_next.bvalid = 1'b1;
            q_next.bresp = RESP_OKAY;
            case ({q_next.aw_addr[ADDR_W-1:2], WORD_LSB_ZERO})
                OFS_IMG0: base = 0;
                OFS_IMG1: base = DATA_W;
                OFS_IMG2: base = 2 * DATA_W;
                OFS_IMG3: base = 3 * DATA_W;
                OFS_PLLC: base = -1;
                OFS_RATIO: base = -1;
                default: begin
                    base = -1;
                    q_next.bresp = RESP_SLVERR;
                end
            endcase
            // Byte lanes of an image word; status words ignore writes
            if (base >= 0) begin
                for (int b = 0; b < STRB_W; b++) begin
                    if (q_next.w_strb[b]) begin
                        q_next.img[base + b * BYTE_W +: BYTE_W] =
                            q_next.w_data[b * BYTE_W +: BYTE_W];
                    end
                end
            end
        end
        // Read answers one cycle after the address is taken
        if (arvalid && q_reg.arready) begin
            q_next.rvalid = 1'b1;
            q_next.rresp = RESP_OKAY;
            case ({araddr[ADDR_W-1:2], WORD_LSB_ZERO})
                OFS_IMG0: q_next.rdata = q_reg.img[0 +: DATA_W];
                OFS_IMG1: q_next.rdata = q_reg.img[DATA_W +: DATA_W];
                OFS_IMG2: q_next.rdata = q_reg.img[2*DATA_W +: DATA_W];
                OFS_IMG3: q_next.rdata = q_reg.img[3*DATA_W +: DATA_W];
                OFS_PLLC: q_next.rdata = {10'h000, q_reg.fb_c, q_reg.ref_c,
                    q_reg.cp[2], q_reg.lf[2], q_reg.sel};
                OFS_RATIO: q_next.rdata = {8'h00, q_reg.ratio};
                default: begin
                    q_next.rdata = '0;
                    q_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        q_next.awready = !q_next.aw_got && !q_next.bvalid;
        q_next.wready = !q_next.w_got && !q_next.bvalid;
        q_next.arready = !q_next.rvalid;
        // Power-down enables act only with the input high
        q_next.off_pll[0] = q_reg.img[OFF_PLL_A] && powerdown_input; // R2 R13
        q_next.off_pll[1] = q_reg.img[OFF_PLL_B] && powerdown_input; // R2 R13
        q_next.off_pll[2] = q_reg.img[OFF_PLL_C] && powerdown_input; // R2 R13
        q_next.off_out[0] = q_reg.img[OFF_OUT_A] && powerdown_input; // R1 R13
        q_next.off_out[1] = q_reg.img[OFF_OUT_B] && powerdown_input; // R1 R13
        q_next.off_out[2] = q_reg.img[OFF_OUT_C] && powerdown_input; // R1 R13
        q_next.off_out[3] = q_reg.img[OFF_OUT_D] && powerdown_input; // R1 R13
        // PLL A and B loop settings
        q_next.ref_a = q_reg.img[REF_A_LO +: REF_W]; // R3
        q_next.ref_b = q_reg.img[REF_B_LO +: REF_W]; // R3
        q_next.fb_a = q_reg.img[FB_A_LO +: FB_W]; // R4
        q_next.fb_b = q_reg.img[FB_B_LO +: FB_W]; // R4
        q_next.lf[0] = q_reg.img[LF_A]; // R11
        q_next.lf[1] = q_reg.img[LF_B]; // R11
        q_next.cp[0] = q_reg.img[PUMP_A]; // R12
        q_next.cp[1] = q_reg.img[PUMP_B]; // R12
        // PLL C takes the set chosen by the pin
        q_next.sel = alt_set_select_pin;
        if (alt_set_select_pin) begin
            q_next.ref_c = q_reg.img[REF_C2_LO +: REF_W]; // R3 R6
            q_next.fb_c = q_reg.img[FB_C2_LO +: FB_W]; // R5 R6
            q_next.lf[2] = q_reg.img[LF_C2]; // R6 R11
            q_next.cp[2] = q_reg.img[PUMP_C2]; // R6 R12
        end else begin
            q_next.ref_c = q_reg.img[REF_C1_LO +: REF_W]; // R3 R6
            q_next.fb_c = q_reg.img[FB_C1_LO +: FB_W]; // R5 R6
            q_next.lf[2] = q_reg.img[LF_C1]; // R6 R11
            q_next.cp[2] = q_reg.img[PUMP_C1]; // R6 R12
        end
        for (int k = 0; k < NUM_OUT; k++) begin
            q_next.ratio[k] = ratio_w[k]; // R10
        end
        // Synchronous clear of all state
        if (rst) begin
            q_next = '0;
            q_next.img = IMG_RESET; // R14
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        q_reg <= q_next;
    end

    // Outputs straight from the state register
    assign awready = q_reg.awready;
    assign wready = q_reg.wready;
    assign bvalid = q_reg.bvalid;
    assign bresp = q_reg.bresp;
    assign arready = q_reg.arready;
    assign rvalid = q_reg.rvalid;
    assign rresp = q_reg.rresp;
    assign rdata = q_reg.rdata;
    assign pll_a_shutdown_en = q_reg.off_pll[0];
    assign pll_b_shutdown_en = q_reg.off_pll[1];
    assign pll_c_shutdown_en = q_reg.off_pll[2];
    assign outdiv_a_shutdown_en = q_reg.off_out[0];
    assign outdiv_b_shutdown_en = q_reg.off_out[1];
    assign outdiv_c_shutdown_en = q_reg.off_out[2];
    assign outdiv_d_shutdown_en = q_reg.off_out[3];
    assign ref_divisor_a = q_reg.ref_a;
    assign ref_divisor_b = q_reg.ref_b;
    assign ref_divisor_c = q_reg.ref_c;
    // Low bits are the A-counter, high bits the M-counter
    assign loop_acount_a = q_reg.fb_a[ACNT_W-1:0]; // R4
    assign loop_mcount_a = q_reg.fb_a[FB_W-1:ACNT_W]; // R4
    assign loop_acount_b = q_reg.fb_b[ACNT_W-1:0]; // R4
    assign loop_mcount_b = q_reg.fb_b[FB_W-1:ACNT_W]; // R4
    assign loop_acount_c = q_reg.fb_c[ACNT_W-1:0]; // R5
    assign loop_mcount_c = q_reg.fb_c[FB_W-1:ACNT_W]; // R5
    assign filter_long_a = q_reg.lf[0];
    assign filter_long_b = q_reg.lf[1];
    assign filter_long_c = q_reg.lf[2];
    assign pump_high_a = q_reg.cp[0];
    assign pump_high_b = q_reg.cp[1];
    assign pump_high_c = q_reg.cp[2];
    assign outdiv_ratio_a = q_reg.ratio[0];
    assign outdiv_ratio_b = q_reg.ratio[1];
    assign outdiv_ratio_c = q_reg.ratio[2];
    assign outdiv_ratio_d = q_reg.ratio[3];

    // Checks on the decoded outputs, the image reset and the bus handshakes
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_outdiv_off_gate: assert property ( // R1
        ##1 outdiv_d_shutdown_en ==
            ($past(q_reg.img[OFF_OUT_D]) && $past(powerdown_input)))
        else $error("divider D shutdown mismatch");
    a_pll_off_gate: assert property ( // R2
        ##1 pll_c_shutdown_en ==
            ($past(q_reg.img[OFF_PLL_C]) && $past(powerdown_input)))
        else $error("PLL C shutdown mismatch");
    a_low_input_runs: assert property ( // R13
        !powerdown_input |=> !pll_a_shutdown_en && !pll_b_shutdown_en &&
            !outdiv_a_shutdown_en && !outdiv_b_shutdown_en)
        else $error("shutdown while power-down low");
    a_ref_b_field: assert property ( // R3
        ##1 ref_divisor_b == $past(q_reg.img[REF_B_LO +: REF_W]))
        else $error("reference B wrong");
    a_fb_a_split: assert property ( // R4
        ##1 loop_mcount_a == $past(q_reg.img[FB_A_LO+ACNT_W +: MCNT_W]) &&
            loop_acount_a == $past(q_reg.img[FB_A_LO +: ACNT_W]))
        else $error("feedback A split wrong");
    a_fb_c_select: assert property ( // R5
        alt_set_select_pin |=>
            loop_mcount_c == $past(q_reg.img[FB_C2_LO+ACNT_W +: MCNT_W]))
        else $error("feedback C set 2 wrong");
    a_ref_c_set1: assert property ( // R6
        !alt_set_select_pin |=> ref_divisor_c ==
            $past(q_reg.img[REF_C1_LO +: REF_W]) &&
            filter_long_c == $past(q_reg.img[LF_C1]))
        else $error("PLL C set 1 not applied");
    a_ratio_b_fixed: assert property ( // R7
        $stable(q_reg.img[CODE_B_LO +: CODE_W]) && q_reg.img[CODE_B_LO +:
            CODE_W] == 4'hF |=> outdiv_ratio_b == 6'h32)
        else $error("divider B ratio wrong");
    a_post_c_sel: assert property ( // R8
        alt_set_select_pin && q_reg.img[CODE_C2_LO +: CODE_W] == 4'h9
            |=> outdiv_ratio_c == 6'h0C)
        else $error("divider C set 2 ratio wrong");
    a_post_d_sel: assert property ( // R9
        !alt_set_select_pin && q_reg.img[CODE_D1_LO +: CODE_W] == 4'hF
            |=> outdiv_ratio_d == 6'h32)
        else $error("divider D set 1 ratio wrong");
    a_ratio_zero_code: assert property ( // R10
        code_sel[0] == 4'h0 |=> outdiv_ratio_a == 6'h01)
        else $error("code zero must divide by one");
    a_filter_pump_b: assert property ( // R11 R12
        ##1 filter_long_b == $past(q_reg.img[LF_B]) &&
            pump_high_b == $past(q_reg.img[PUMP_B]))
        else $error("PLL B tuning wrong");
    a_image_clear: assert property ( // R14
        @(posedge mclk) disable iff (1'b0)
        rst |=> q_reg.img == IMG_RESET)
        else $error("image not cleared");
    a_bvalid_hold: assert property (
        bvalid && !bready |=> bvalid)
        else $error("write response dropped");

    c_write_done: cover property (bvalid && bready);
    c_read_done: cover property (rvalid && rready);
    c_set_switch: cover property ($rose(alt_set_select_pin));
    c_shutdown: cover property (powerdown_input ##1 pll_a_shutdown_en);
endmodule

/* verification/test_pll_clock_config_decode.sv */
// Purpose: Self-checking bench for the clock generator image decoder
// Assumes: AXI4-Lite answers within a few cycles; outputs lag by one edge
// Notes: Shutdown and field scenarios write a whole image; the others write single words or only read
`timescale 1ns/1ps
module test_pll_clock_config_decode
    import pll_cfg_pkg::*;
;
    logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp;
    logic alt_set_select_pin, powerdown_input;
    logic pll_a_shutdown_en, pll_b_shutdown_en, pll_c_shutdown_en;
    logic outdiv_a_shutdown_en, outdiv_b_shutdown_en;
    logic outdiv_c_shutdown_en, outdiv_d_shutdown_en;
    logic [REF_W-1:0] ref_divisor_a, ref_divisor_b, ref_divisor_c;
    logic [ACNT_W-1:0] loop_acount_a, loop_acount_b, loop_acount_c;
    logic [MCNT_W-1:0] loop_mcount_a, loop_mcount_b, loop_mcount_c;
    logic filter_long_a, filter_long_b, filter_long_c;
    logic pump_high_a, pump_high_b, pump_high_c;
    logic [RATIO_W-1:0] outdiv_ratio_a, outdiv_ratio_b;
    logic [RATIO_W-1:0] outdiv_ratio_c, outdiv_ratio_d;
    logic [IMG_W-1:0] img;
    logic [1:0] resp;
    logic [DATA_W-1:0] rd_word;
    int errors = 0;
    int n_tests = 0;
    // Divide ratio expected for each modulus code
    localparam logic [5:0] RT [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
        6'h06, 6'h08, 6'h09, 6'h0A, 6'h0C, 6'h0F, 6'h10, 6'h12, 6'h14,
        6'h19, 6'h32};

    pll_clock_config_decode i_dut (
        .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .alt_set_select_pin(alt_set_select_pin),
        .powerdown_input(powerdown_input),
        .pll_a_shutdown_en(pll_a_shutdown_en),
        .pll_b_shutdown_en(pll_b_shutdown_en),
        .pll_c_shutdown_en(pll_c_shutdown_en),
        .outdiv_a_shutdown_en(outdiv_a_shutdown_en),
        .outdiv_b_shutdown_en(outdiv_b_shutdown_en),
        .outdiv_c_shutdown_en(outdiv_c_shutdown_en),
        .outdiv_d_shutdown_en(outdiv_d_shutdown_en),
        .ref_divisor_a(ref_divisor_a), .ref_divisor_b(ref_divisor_b),
        .ref_divisor_c(ref_divisor_c), .loop_acount_a(loop_acount_a),
        .loop_mcount_a(loop_mcount_a), .loop_acount_b(loop_acount_b),
        .loop_mcount_b(loop_mcount_b), .loop_acount_c(loop_acount_c),
        .loop_mcount_c(loop_mcount_c), .filter_long_a(filter_long_a),
        .filter_long_b(filter_long_b), .filter_long_c(filter_long_c),
        .pump_high_a(pump_high_a), .pump_high_b(pump_high_b),
        .pump_high_c(pump_high_c), .outdiv_ratio_a(outdiv_ratio_a),
        .outdiv_ratio_b(outdiv_ratio_b), .outdiv_ratio_c(outdiv_ratio_c),
        .outdiv_ratio_d(outdiv_ratio_d)
    );

    // Clock, 100 ns period
    always #50 mclk = ~mclk;

    // Final counts and verdict
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One comparison, mismatch reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
            errors++;
        end
    endtask

    // Bus write; entered and left just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        bit got;
        got = 0;
        r = 2'h3;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                got = 1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        if (!got) begin
            errors++;
            summarize();
        end
        // Idle edge so the next call never drives bready twice in a step
        @(posedge mclk);
    endtask

    // Bus read; rready held until the answer is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        bit got;
        got = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = 1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        if (!got) begin
            errors++;
            summarize();
        end
        // Idle edge so the next call never drives rready twice in a step
        @(posedge mclk);
    endtask

    // Let image and pin changes reach the decoded outputs
    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask

    // Whole image in four words
    task automatic put_img();
        for (int i = 0; i < 4; i++) begin
            wr(8'(4 * i), img[32 * i +: 32], resp);
            chk(resp, RESP_OKAY);
        end
        settle();
    endtask

    // Cleared image after reset, ratios at divide by one
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i), rd_word, resp);
            chk(rd_word, 32'h0);
        end
        chk({outdiv_ratio_d, outdiv_ratio_c, outdiv_ratio_a}, 18'h01041);
        chk(pll_a_shutdown_en, 1'b0);
        $display("test reset done");
    endtask

    // Shutdown enables gated by the power-down input
    task automatic t_shutdown();
        img = '0;
        img[21] = 1'b1;
        img[45] = 1'b1;
        img[69] = 1'b1;
        img[123:120] = 4'hF;
        put_img();
        chk({pll_c_shutdown_en, pll_b_shutdown_en, pll_a_shutdown_en,
            outdiv_d_shutdown_en, outdiv_c_shutdown_en,
            outdiv_b_shutdown_en, outdiv_a_shutdown_en}, 7'h00);
        powerdown_input <= 1'b1;
        settle();
        chk({pll_c_shutdown_en, pll_b_shutdown_en, pll_a_shutdown_en}, 3'h7);
        img[123:120] = 4'h5;
        img[45] = 1'b0;
        put_img();
        chk({outdiv_d_shutdown_en, outdiv_c_shutdown_en,
            outdiv_b_shutdown_en, outdiv_a_shutdown_en}, 4'h5);
        chk({pll_c_shutdown_en, pll_b_shutdown_en, pll_a_shutdown_en}, 3'h5);
        powerdown_input <= 1'b0;
        settle();
        chk(outdiv_a_shutdown_en, 1'b0);
        $display("test shutdown done");
    endtask

    // Dividers, counters and tuning for both PLL C sets
    task automatic t_fields();
        img = '0;
        img[7:0] = 8'hA5;
        img[19:8] = 12'hDB3;
        img[31:24] = 8'h3C;
        img[44:32] = 13'h12CE;
        img[55:48] = 8'h81;
        img[67:56] = 12'hFF1;
        img[79:72] = 8'h18;
        img[92:80] = 13'h100E;
        img[119:96] = 24'h09F6E3;
        put_img();
        chk({ref_divisor_a, loop_mcount_a, loop_acount_a}, 19'h52DB3);
        chk({pump_high_a, filter_long_a}, 2'h2);
        chk({ref_divisor_b, loop_mcount_b, loop_acount_b}, 19'h1E2CE);
        chk({pump_high_b, filter_long_b}, 2'h1);
        chk({ref_divisor_c, loop_mcount_c, loop_acount_c}, 19'h40FF1);
        chk({pump_high_c, filter_long_c}, 2'h2);
        chk({outdiv_ratio_a, outdiv_ratio_b}, {RT[3], RT[14]});
        chk({outdiv_ratio_c, outdiv_ratio_d}, {RT[6], RT[15]});
        alt_set_select_pin <= 1'b1;
        settle();
        chk({ref_divisor_c, loop_mcount_c, loop_acount_c}, 19'h0C00E);
        chk({pump_high_c, filter_long_c}, 2'h1);
        chk({outdiv_ratio_c, outdiv_ratio_d}, {RT[9], RT[0]});
        chk({outdiv_ratio_a, outdiv_ratio_b}, {RT[3], RT[14]});
        chk(ref_divisor_a, 8'hA5);
        alt_set_select_pin <= 1'b0;
        settle();
        $display("test fields done");
    endtask

    // Every modulus code on dividers A and B
    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            wr(OFS_IMG3, {24'h0, 4'(15 - c), 4'(c)}, resp);
            settle();
            chk({outdiv_ratio_a, outdiv_ratio_b}, {RT[c], RT[15 - c]});
        end
        $display("test codes done");
    endtask

    // Unmapped place, status write, image read back
    task automatic t_bus();
        wr(8'h20, 32'hFFFF_FFFF, resp);
        chk(resp, RESP_SLVERR);
        rd(8'h20, rd_word, resp);
        chk({resp, rd_word}, {RESP_SLVERR, 32'h0});
        wr(OFS_IMG2, 32'h0000_1234, resp);
        wr(OFS_PLLC, 32'hFFFF_FFFF, resp);
        chk(resp, RESP_OKAY);
        rd(OFS_IMG2, rd_word, resp);
        chk({resp, rd_word}, {RESP_OKAY, 32'h0000_1234});
        rd(OFS_RATIO, rd_word, resp);
        chk(rd_word, {8'h00, RT[0], RT[0], RT[0], RT[15]});
        alt_set_select_pin <= 1'b1;
        settle();
        chk(ref_divisor_c, 8'h12);
        alt_set_select_pin <= 1'b0;
        $display("test bus done");
    endtask

    // Main sequence with reset held three cycles
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        alt_set_select_pin = 1'b0;
        powerdown_input = 1'b0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_shutdown();
        t_fields();
        t_codes();
        t_bus();
        summarize();
    end
endmodule
